// ==== src/ssar_pkg.sv ====
/*
  Shared constants and types for the serial converter readout link.
  Assumes a 250 MHz system clock on both ends of the link.
*/
package ssar_pkg;
  localparam int SSAR_CLK_PERIOD_NS = 4; // System clock period
  localparam int SSAR_FRAME_BITS = 16; // Clocks per frame
  localparam int SSAR_TRACK_EDGE = 13; // Falling edges before tracking
  localparam int SSAR_LAST_LAUNCH = 15; // Edge that launches the last bit
  localparam int SSAR_LEAD_ZEROS = 4; // Leading zero bits
  localparam int SSAR_RES12 = 12; // Wide variant width
  localparam int SSAR_RES10 = 10; // Narrow variant width
  localparam int SSAR_ACQ_NS = 290; // Least acquisition time
  localparam int SSAR_QUIET_NS = 60; // Least quiet time
  localparam int SSAR_ACQ_CYC = (SSAR_ACQ_NS + SSAR_CLK_PERIOD_NS - 1) / SSAR_CLK_PERIOD_NS;
  localparam int SSAR_QUIET_CYC = (SSAR_QUIET_NS + SSAR_CLK_PERIOD_NS - 1) / SSAR_CLK_PERIOD_NS;
  localparam int SSAR_HALF_DIV = 8; // Host half period of serial clock in cycles
  localparam logic [4:0] SSAR_CNT_ZERO = 5'h00; // Counter reset value
  localparam logic [11:0] SSAR_WORD_ZERO = 12'h000; // Word reset value
  typedef enum logic [1:0] {SSAR_IDLE, SSAR_RUN, SSAR_GAP} ssar_state_t;
endpackage

// ==== src/ssar_if.sv ====
/*
  Interface carrying the frame select, serial clock and serial result line.
  Assumes the bench resolves the result line from its output enable.
*/
`timescale 1ns/10ps
`default_nettype none
interface ssar_if;
  logic frame_sel_n; // Frame select, active low
  logic sclk; // Serial clock from host
  logic serial_result_out; // Device data level
  logic serial_result_oe; // High while device drives line
  modport dev (input frame_sel_n, input sclk, output serial_result_out, output serial_result_oe);
  modport host (output frame_sel_n, output sclk, input serial_result_out, input serial_result_oe);
endinterface
`default_nettype wire

// ==== src/ssar_buf2.sv ====
/*
  Two-entry valid/ready buffer for result words.
  Assumes both sides run on sys_clk with synchronous reset.
*/
`timescale 1ns/10ps
`default_nettype none
module ssar_buf2
  import ssar_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [11:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [11:0] out_data
);
  typedef struct packed {
    logic [1:0][11:0] mem; // Entries
    logic rd; // Read slot
    logic wr; // Write slot
    logic [1:0] cnt; // Fill level
  } ssar_buf_t;
  ssar_buf_t st_r, st_nxt;
  logic push, pop;

  // Handshake terms
  assign in_ready = (st_r.cnt != 2'h2);
  assign out_valid = (st_r.cnt != 2'h0);
  assign out_data = st_r.mem[st_r.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data;
      st_nxt.wr = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + 2'h1;
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - 2'h1;
    end
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== src/ssar_dev.sv ====
/*
  Device end: converter framing, sampling and serial result shift.
  Assumes link pins are asynchronous to sys_clk; analog value arrives as
  a sampled code on analog_code.
*/
`timescale 1ns/10ps
`default_nettype none
module ssar_dev
  import ssar_pkg::*;
#(
  parameter bit NARROW = 1'b0 // Ten-bit variant when set
) (
  input wire logic sys_clk,
  input wire logic rst,
  ssar_if.dev link,
  input wire logic [11:0] analog_code,
  output logic tracking,
  output logic converting
);
  typedef struct packed {
    logic [1:0] cs_s; // Select synchroniser
    logic [1:0] ck_s; // Clock synchroniser
    logic cs_d; // Previous select
    logic ck_d; // Previous clock
    logic [4:0] cnt; // Falling edge count
    logic [15:0] sh; // Frame shift
    logic oe; // Output drive
    logic run; // Frame active
    logic trk; // Track-and-hold tracking
    logic trk_pend; // Track on next rise
  } ssar_dev_t;
  ssar_dev_t st_r, st_nxt;
  logic cs_fall, cs_rise, ck_fall, ck_rise;
  logic [11:0] code_w;

  // Edge detection off the second stages only
  assign cs_fall = st_r.cs_d && !st_r.cs_s[1];
  assign cs_rise = !st_r.cs_d && st_r.cs_s[1];
  assign ck_fall = st_r.ck_d && !st_r.ck_s[1];
  assign ck_rise = !st_r.ck_d && st_r.ck_s[1];
  // Narrow code keeps upper ten bits; two trailing zeros fill in
  assign code_w = NARROW ? {analog_code[11:2], 2'h0} : analog_code;

  assign link.serial_result_out = st_r.sh[15];
  assign link.serial_result_oe = st_r.oe;
  assign tracking = st_r.trk;
  assign converting = st_r.run;

  // Frame sequencing
  always_comb begin
    st_nxt = st_r;
    st_nxt.cs_s = {st_r.cs_s[0], link.frame_sel_n};
    st_nxt.ck_s = {st_r.ck_s[0], link.sclk};
    st_nxt.cs_d = st_r.cs_s[1];
    st_nxt.ck_d = st_r.ck_s[1];
    if (cs_fall) begin
      // Hold, sample and drive the first leading zero
      st_nxt.trk = 1'b0;
      st_nxt.trk_pend = 1'b0;
      st_nxt.run = 1'b1;
      st_nxt.oe = 1'b1;
      st_nxt.cnt = SSAR_CNT_ZERO;
      st_nxt.sh = {4'h0, code_w};
    end else if (cs_rise && st_r.run) begin
      // Early end abandons the frame
      st_nxt.run = 1'b0;
      st_nxt.oe = 1'b0;
      st_nxt.trk = 1'b1;
      st_nxt.trk_pend = 1'b0;
    end else if (st_r.run && ck_fall) begin
      st_nxt.cnt = st_r.cnt + 5'h01;
      st_nxt.sh = {st_r.sh[14:0], 1'b0};
      if (st_r.cnt == 5'(SSAR_TRACK_EDGE - 1)) begin
        st_nxt.trk_pend = 1'b1;
      end
      if (st_r.cnt == 5'(SSAR_FRAME_BITS - 1)) begin
        // Frame done after all clocks
        st_nxt.run = 1'b0;
        st_nxt.oe = 1'b0;
      end
    end
    if (st_r.trk_pend && ck_rise && !cs_fall) begin
      st_nxt.trk = 1'b1;
      st_nxt.trk_pend = 1'b0;
    end
    if (!st_r.run && !cs_fall) begin
      st_nxt.oe = 1'b0;
    end
  end

  // State register; idle means tracking with a floating line
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.cs_s <= 2'h3;
      st_r.cs_d <= 1'b1;
      st_r.trk <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== src/ssar_host.sv ====
/*
  Host end: makes the serial clock by division, frames conversions and
  collects the result words through a two-entry buffer.
  Assumes the device end follows the same frame timing.
*/
`timescale 1ns/10ps
`default_nettype none
module ssar_host
  import ssar_pkg::*;
#(
  parameter bit NARROW = 1'b0 // Ten-bit variant when set
) (
  input wire logic sys_clk,
  input wire logic rst,
  ssar_if.host link,
  input wire logic start,
  output logic busy,
  output logic word_valid,
  input wire logic word_ready,
  output logic [11:0] word_data
);
  typedef struct packed {
    ssar_state_t state; // Sequencer
    logic cs_n; // Frame select drive
    logic ck; // Serial clock drive
    logic [3:0] div; // Half period count
    logic [4:0] cnt; // Falling edges made
    logic [1:0] d_s; // Data synchroniser
    logic [15:0] sh; // Captured bits
    logic push; // Word offer
    logic [11:0] word; // Offered word
    logic [7:0] gap; // Acquisition and quiet wait
  } ssar_host_t;
  ssar_host_t st_r, st_nxt;
  logic in_ready;
  localparam int GAP_CYC = (SSAR_ACQ_CYC > SSAR_QUIET_CYC) ? SSAR_ACQ_CYC : SSAR_QUIET_CYC;

  assign link.frame_sel_n = st_r.cs_n;
  assign link.sclk = st_r.ck;
  assign busy = (st_r.state != SSAR_IDLE) || st_r.push;

  ssar_buf2 u_buf (
    .sys_clk(sys_clk),
    .rst(rst),
    .in_valid(st_r.push),
    .in_ready(in_ready),
    .in_data(st_r.word),
    .out_valid(word_valid),
    .out_ready(word_ready),
    .out_data(word_data)
  );

  // Sequencer; a pending word stalls new frames
  always_comb begin
    st_nxt = st_r;
    st_nxt.d_s = {st_r.d_s[0], link.serial_result_out};
    if (st_r.push && in_ready) begin
      st_nxt.push = 1'b0;
    end
    case (st_r.state)
      SSAR_IDLE: begin
        if (start && !st_r.push) begin
          st_nxt.cs_n = 1'b0;
          st_nxt.cnt = SSAR_CNT_ZERO;
          st_nxt.div = 4'h0;
          st_nxt.state = SSAR_RUN;
        end
      end
      SSAR_RUN: begin
        st_nxt.div = st_r.div + 4'h1;
        if (st_r.div == 4'(SSAR_HALF_DIV - 1)) begin
          st_nxt.div = 4'h0;
          st_nxt.ck = ~st_r.ck;
          if (st_r.ck) begin
            // Capture at falling edge, full sixteen clocks
            st_nxt.sh = {st_r.sh[14:0], st_r.d_s[1]};
            st_nxt.cnt = st_r.cnt + 5'h01;
            if (st_r.cnt == 5'(SSAR_FRAME_BITS - 1)) begin
              st_nxt.cs_n = 1'b1;
              st_nxt.push = 1'b1;
              st_nxt.word = NARROW ? {st_r.sh[10:1], 2'h0} : {st_r.sh[10:0], st_r.d_s[1]};
              st_nxt.gap = 8'h00;
              st_nxt.state = SSAR_GAP;
            end
          end
        end
      end
      SSAR_GAP: begin
        // Hold select high for acquisition and quiet time
        // Slower than the advised eighteen-clock frame, but same margins
        st_nxt.gap = st_r.gap + 8'h01;
        if (st_r.gap == 8'(GAP_CYC)) begin
          st_nxt.state = SSAR_IDLE;
        end
      end
      default: begin
        st_nxt.state = SSAR_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_r <= '0;
      st_r.state <= SSAR_IDLE;
      st_r.cs_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule
`default_nettype wire

// ==== verif/ssar_link_monitor.sv ====
/*
  Checker for the link joining host and device ends.
  Assumes sys_clk samples the link and rst is synchronous, active high.
*/
`timescale 1ns/10ps
`default_nettype none
module ssar_link_monitor
  import ssar_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic frame_sel_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  logic [8:0] age_r; // Cycles since select fell
  logic [6:0] high_r; // Cycles select stayed high
  logic [4:0] falls_r; // Clock falls in this frame
  // Age and high counters saturate so long idles never wrap; falls_r does not saturate
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      age_r <= 9'h1ff;
      high_r <= 7'h7f;
      falls_r <= 5'h00;
    end else begin
      age_r <= $fell(frame_sel_n) ? 9'h000 : age_r + {8'h00, age_r != 9'h1ff};
      high_r <= !frame_sel_n ? 7'h00 : high_r + {6'h00, high_r != 7'h7f};
      falls_r <= $fell(frame_sel_n) ? 5'h00 : falls_r + {4'h0, $fell(sclk)};
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence quiet_s; frame_sel_n [*8]; endsequence
  sequence start_s; $fell(frame_sel_n); endsequence
  idle_float_a: assert property (quiet_s |-> !serial_result_oe)
    else $error("Line driven while deselected");
  sel_drive_a: assert property (start_s |-> ##[1:6] serial_result_oe)
    else $error("Line not driven after select fell");
  drive_owner_a: assert property ($rose(serial_result_oe) |-> !frame_sel_n)
    else $error("Line driven without select");
  bit_edge_a: assert property (serial_result_oe && $past(serial_result_oe)
    && $changed(serial_result_out) |-> !sclk)
    else $error("Bit changed outside clock low phase");
  lead_zero_a: assert property (serial_result_oe && age_r < 9'h032
    |-> !serial_result_out)
    else $error("Leading bit not zero");
  frame_len_a: assert property ($fell(serial_result_oe)
    |-> age_r inside {[9'h0f0:9'h118]})
    else $error("Frame length wrong");
  clock_count_a: assert property ($rose(frame_sel_n) |-> ##1 falls_r == 5'h10)
    else $error("Frame did not hold sixteen clocks");
  last_bit_a: assert property ($fell(sclk) && falls_r == 5'h0f |-> serial_result_oe)
    else $error("Line released before last capture");
  quiet_gap_a: assert property (start_s |-> high_r >= SSAR_QUIET_CYC)
    else $error("Select quiet time too short");
endmodule
`default_nettype wire

// ==== verif/serial_sar_adc_readout_bench.sv ====
/*
  Bench: host and wide device on one link; a narrow device on a second
  link driven by bench tasks. Assumes a 250 MHz sys_clk.
*/
`timescale 1ns/10ps
`default_nettype none
module serial_sar_adc_readout_bench
  import ssar_pkg::*;
;
  logic sys_clk = 1'b0; // System clock
  logic rst = 1'b1; // Synchronous reset
  logic start = 1'b0; // Host frame request
  logic word_ready = 1'b0; // Drain side of buffer
  logic [11:0] code = 12'h000; // Shared analog code
  logic busy, word_valid, tracking, tracking2, conv2, sd2;
  logic [11:0] word_data; // Host result word
  logic [15:0] got; // Narrow frame as captured
  int err_total = 0;
  int samples_checked = 0;
  // Rows: code, wide word, narrow frame
  logic [39:0] rows [5] = '{40'h000_000_0000, 40'hfff_fff_0ffc,
    40'ha5c_a5c_0a5c, 40'h001_001_0000, 40'h801_801_0800};
  ssar_if lnk();
  ssar_if lnk2();
  // Undriven line shows z so a stale bit never passes
  assign sd2 = lnk2.serial_result_oe ? lnk2.serial_result_out : 1'bz;
  always #2 sys_clk = ~sys_clk;
  ssar_dev #(.NARROW(1'b0)) ssar_dev_i (.sys_clk, .rst, .link(lnk.dev),
    .analog_code(code), .tracking, .converting());
  ssar_host #(.NARROW(1'b0)) ssar_host_i (.sys_clk, .rst, .link(lnk.host),
    .start, .busy, .word_valid, .word_ready, .word_data);
  ssar_dev #(.NARROW(1'b1)) ssar_dev_i2 (.sys_clk, .rst, .link(lnk2.dev),
    .analog_code(code), .tracking(tracking2), .converting(conv2));
  ssar_link_monitor ssar_link_monitor_i (.sys_clk, .rst,
    .frame_sel_n(lnk.frame_sel_n), .sclk(lnk.sclk),
    .serial_result_out(lnk.serial_result_out), .serial_result_oe(lnk.serial_result_oe));
  initial begin
    lnk2.frame_sel_n = 1'b1;
    lnk2.sclk = 1'b0;
  end
  // One comparison, four-state
  task automatic cmp(input string what, input logic [15:0] exp, input logic [15:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // Host frame; hold delays the drain to stall the buffer
  task automatic run(input logic [11:0] c, input logic [11:0] exp, input int hold);
    int t;
    t = 0;
    code = c;
    start = 1'b1;
    while (busy !== 1'b1 && t < 100) begin
      @(negedge sys_clk);
      t++;
    end
    start = 1'b0;
    while (word_valid !== 1'b1 && t < 2000) begin
      @(negedge sys_clk);
      t++;
    end
    repeat (hold) @(negedge sys_clk);
    cmp("valid", 16'h0001, {15'h0, word_valid});
    cmp("word", {4'h0, exp}, {4'h0, word_data});
    word_ready = 1'b1;
    @(negedge sys_clk);
    word_ready = 1'b0;
    @(negedge sys_clk);
  endtask
  // Bench as host on link two; n clocks, captures before each fall
  task automatic frame2(input int n);
    lnk2.frame_sel_n = 1'b0;
    repeat (8) @(negedge sys_clk);
    for (int i = 1; i <= n; i++) begin
      lnk2.sclk = 1'b1;
      repeat (8) @(negedge sys_clk);
      got = {got[14:0], sd2}; // Late in the high phase
      cmp("track", {15'h0, i >= 14}, {15'h0, tracking2});
      lnk2.sclk = 1'b0;
      repeat (8) @(negedge sys_clk);
    end
    if (n == 16) begin
      cmp("float", {15'h0, 1'bz}, {15'h0, sd2});
    end
    lnk2.frame_sel_n = 1'b1;
    // An abort resumes tracking at once, so wait out acquisition
    repeat (SSAR_ACQ_CYC) @(negedge sys_clk);
    cmp("idle", {15'h0, 1'bz}, {15'h0, sd2});
    cmp("conv", 16'h0000, {15'h0, conv2});
  endtask
  // Hang guard, a few times the expected run
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    for (int r = 0; r < 5; r++) begin
      run(rows[r][39:28], rows[r][27:16], 0);
      frame2(16);
      cmp("narrow", rows[r][15:0], got);
    end
    $display("Test table done");
    run(12'h5a3, 12'h5a3, 300);
    $display("Test stall done");
    frame2(5);
    frame2(16);
    cmp("rerun", 16'h05a0, got);
    $display("Test abort done");
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    cmp("oe", 16'h0000, {15'h0, lnk.serial_result_oe});
    cmp("sel", 16'h0001, {15'h0, lnk.frame_sel_n});
    cmp("busy", 16'h0000, {15'h0, busy});
    cmp("tracking", 16'h0001, {15'h0, tracking});
    $display("Test reset done");
    report_and_stop;
  end
endmodule
`default_nettype wire
